// >>> logic/slm_pkg.sv
// Shared constants for the supply loss monitor: timing, I2C map, states.
// Assumes a 100 MHz system clock and a rail sample in tenths of a volt.
package slm_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SLOW_US = 16;
  localparam int unsigned FAST_US = 8;
  localparam int unsigned SPIKE_US = 250;
  localparam int unsigned TUNE_US = 1000;
  localparam int unsigned SLOW_CYC = SLOW_US * CLK_MHZ;
  localparam int unsigned FAST_CYC = FAST_US * CLK_MHZ;
  localparam int unsigned OBS_CYC_DEF = SPIKE_US * CLK_MHZ;
  localparam int unsigned TUNE_CYC_DEF = TUNE_US * CLK_MHZ;
  localparam int unsigned TICK_W = 12;
  localparam int unsigned CNT_W = 24;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [6:0] I2C_ADDR = 7'h69;
  localparam logic [7:0] REG_TRIP_LO = 8'h02;
  localparam logic [7:0] REG_TRIP_HI = 8'h03;
  localparam logic [7:0] REG_SWC_LO = 8'h04;
  localparam logic [7:0] REG_SWC_HI = 8'h05;
  localparam logic [15:0] CAPTURE_RST = 16'h0000;
  localparam logic [15:0] TUNE_MARGIN = 16'h0002;

  // ----------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MON_IDLE = 2'h0,
    MON_WATCH = 2'h1,
    MON_BATT = 2'h3,
    MON_TUNE = 2'h2
  } slm_mon_e;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'h0,
    BUS_ADDR = 3'h1,
    BUS_AACK = 3'h3,
    BUS_WR = 3'h2,
    BUS_WACK = 3'h6,
    BUS_RD = 3'h7,
    BUS_RACK = 3'h5
  } slm_bus_e;

endpackage : slm_pkg

// >>> logic/slm_tick_if.sv
// Link between the monitor and its sampling tick generator.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface slm_tick_if;
  logic fast;
  logic tick;
  modport ctrl (output fast, input tick);
  modport gen (input fast, output tick);
endinterface : slm_tick_if

// >>> logic/slm_tick_gen.sv
// Sampling tick generator: one pulse per slow or fast sampling period.
// Assumes the synchronous active-low reset of the system clock.
`timescale 1ns/1ps
module slm_tick_gen
  import slm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  slm_tick_if.gen tk
);

  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic tick;
  } slm_tick_s;

  slm_tick_s s_q;
  slm_tick_s s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    // A switch to fast mode shortens the running period at once.
    if (s_q.cnt == '0 || (tk.fast && s_q.cnt >= TICK_W'(FAST_CYC)))
    begin
      s_d.tick = 1'b1;
      s_d.cnt = tk.fast ? TICK_W'(FAST_CYC - 1) : TICK_W'(SLOW_CYC - 1);
    end
    else
    begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tk.tick = s_q.tick;

endmodule : slm_tick_gen

// >>> logic/slm_monitor.sv
// Supply loss monitor top: rail sampling, spike filter, backup switch,
// self adjustment and an I2C target holding the two capture registers.
// Assumes rail samples in tenths of a volt, synchronous to I_CLK_SYS.
// What this block does
// - Samples the rail against the threshold once every 16 us.
// - After a trip, samples every 8 us during the observation window.
// - Ignores short drops; switches to battery when window ends still low.
// - On battery keeps sampling; returns to cable once rail stays good.
// - A command starts self adjustment from idle only; no battery backup meanwhile.
// - Capture registers take the raw sample and hold it until next event.
// - Capture registers are read-only; host writes change nothing.
// - Register 0x02 holds rail voltage at comparator trip, 16 bits.
// - Register 0x04 holds rail voltage at battery switch, 16 bits.
// - Registers answer on I2C target address 0x69.
`timescale 1ns/1ps
module slm_monitor
  import slm_pkg::*;
#(
  parameter int unsigned OBS_CYC = slm_pkg::OBS_CYC_DEF,
  parameter int unsigned TUNE_CYC = slm_pkg::TUNE_CYC_DEF
)
(
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic [15:0] I_RAIL_LEVEL,
  input wire logic [15:0] I_REF_LEVEL,
  input wire logic I_TUNE_START,
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA_OUT,
  output logic O_SDA_OE_N,
  output logic O_ON_BATTERY,
  output logic O_TUNE_BUSY,
  output logic O_FAST_SAMPLING
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    slm_mon_e mon;
    logic [CNT_W-1:0] cnt;
    logic [15:0] trip_q;
    logic [15:0] swc_q;
    logic [15:0] tune_min;
    logic [15:0] tune_ref;
    logic tune_valid;
    slm_bus_e bus;
    logic scl_p;
    logic sda_p;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic first;
    logic nack;
    logic oe_n;
  } slm_mon_s;

  slm_mon_s s_q;
  slm_mon_s s_d;
  slm_tick_if tk ();
  logic [15:0] ref_lvl;
  logic below, scl_rise, scl_fall, bus_start, bus_stop;

  slm_tick_gen u_tick (
    .i_clk (I_CLK_SYS),
    .i_nrst (I_NRST),
    .tk (tk.gen)
  );

  assign tk.fast = (s_q.mon == MON_WATCH);
  // Read data for the current pointer; every other address reads zero.
  function automatic logic [7:0] rd_byte(input logic [7:0] p,
                                         input logic [15:0] trip,
                                         input logic [15:0] swc);
    logic [7:0] r;
    r = 8'h00;
    if (p == REG_TRIP_LO)
      r = trip[7:0];
    else if (p == REG_TRIP_HI)
      r = trip[15:8];
    else if (p == REG_SWC_LO)
      r = swc[7:0];
    else if (p == REG_SWC_HI)
      r = swc[15:8];
    return r;
  endfunction : rd_byte

  assign ref_lvl = s_q.tune_valid ? s_q.tune_ref : I_REF_LEVEL;
  assign below = (I_RAIL_LEVEL < ref_lvl);
  assign scl_rise = !s_q.scl_p && I_SCL;
  assign scl_fall = s_q.scl_p && !I_SCL;
  assign bus_start = s_q.scl_p && I_SCL && s_q.sda_p && !I_SDA;
  assign bus_stop = s_q.scl_p && I_SCL && !s_q.sda_p && I_SDA;

  always_comb
  begin
    s_d = s_q;
    s_d.scl_p = I_SCL;
    s_d.sda_p = I_SDA;

    // --------------------------------------------------------------------
    // Rail monitor
    // --------------------------------------------------------------------
    if (s_q.cnt != '1)
      s_d.cnt = s_q.cnt + 1'b1;
    case (s_q.mon)
      MON_IDLE:
      begin
        if (I_TUNE_START)
        begin
          s_d.mon = MON_TUNE;
          s_d.cnt = '0;
          s_d.tune_min = 16'hFFFF;
        end
        else if (tk.tick && below)
        begin
          s_d.mon = MON_WATCH;
          s_d.trip_q = I_RAIL_LEVEL;
          s_d.cnt = '0;
        end
      end
      MON_WATCH:
      begin
        if (tk.tick && !below)
          s_d.mon = MON_IDLE;
        else if (tk.tick && 32'(s_q.cnt) >= OBS_CYC)
        begin
          s_d.mon = MON_BATT;
          s_d.swc_q = I_RAIL_LEVEL;
          s_d.cnt = '0;
        end
      end
      MON_BATT:
      begin
        // The rail must stay good for a whole window before leaving.
        if (tk.tick && below)
          s_d.cnt = '0;
        else if (tk.tick && 32'(s_q.cnt) >= OBS_CYC)
          s_d.mon = MON_IDLE;
      end
      MON_TUNE:
      begin
        // No backup here, so a real loss now goes uncaught.
        if (tk.tick && I_RAIL_LEVEL < s_q.tune_min)
          s_d.tune_min = I_RAIL_LEVEL;
        if (32'(s_q.cnt) >= TUNE_CYC)
        begin
          s_d.mon = MON_IDLE;
          s_d.tune_valid = 1'b1;
          s_d.tune_ref = (s_q.tune_min > TUNE_MARGIN) ?
                         s_q.tune_min - TUNE_MARGIN : 16'h0001;
        end
      end
      default:
        s_d.mon = MON_IDLE;
    endcase

    // --------------------------------------------------------------------
    // I2C target
    // --------------------------------------------------------------------
    case (s_q.bus)
      BUS_ADDR, BUS_WR:
      begin
        if (scl_rise)
        begin
          s_d.sh = {s_q.sh[6:0], I_SDA};
          s_d.bits = s_q.bits + 1'b1;
        end
        else if (scl_fall && s_q.bits == 4'h8)
        begin
          s_d.bits = 4'h0;
          if (s_q.bus == BUS_ADDR)
          begin
            if (s_q.sh[7:1] == I2C_ADDR)
            begin
              s_d.bus = BUS_AACK;
              s_d.rw = s_q.sh[0];
              s_d.oe_n = 1'b0;
            end
            else
              s_d.bus = BUS_IDLE;
          end
          else
          begin
            // The first data byte sets the pointer; later data bytes are acknowledged but never stored.
            s_d.bus = BUS_WACK;
            s_d.oe_n = 1'b0;
            s_d.first = 1'b0;
            s_d.ptr = s_q.first ? s_q.sh : s_q.ptr + 1'b1;
          end
        end
      end
      BUS_AACK:
      begin
        if (scl_fall)
        begin
          if (s_q.rw)
          begin
            s_d.bus = BUS_RD;
            s_d.sh = rd_byte(s_q.ptr, s_q.trip_q, s_q.swc_q);
            s_d.oe_n = s_d.sh[7];
            s_d.bits = 4'h1;
          end
          else
          begin
            s_d.bus = BUS_WR;
            s_d.oe_n = 1'b1;
            s_d.first = 1'b1;
          end
        end
      end
      BUS_WACK:
      begin
        if (scl_fall)
        begin
          s_d.bus = BUS_WR;
          s_d.oe_n = 1'b1;
        end
      end
      BUS_RD:
      begin
        if (scl_fall)
        begin
          if (s_q.bits == 4'h8)
          begin
            s_d.bus = BUS_RACK;
            s_d.oe_n = 1'b1;
            s_d.ptr = s_q.ptr + 1'b1;
          end
          else
          begin
            s_d.sh = {s_q.sh[6:0], 1'b0};
            s_d.oe_n = s_q.sh[6];
            s_d.bits = s_q.bits + 1'b1;
          end
        end
      end
      BUS_RACK:
      begin
        if (scl_rise)
          s_d.nack = I_SDA;
        else if (scl_fall)
        begin
          if (s_q.nack)
            s_d.bus = BUS_IDLE;
          else
          begin
            s_d.bus = BUS_RD;
            s_d.sh = rd_byte(s_q.ptr, s_q.trip_q, s_q.swc_q);
            s_d.oe_n = s_d.sh[7];
            s_d.bits = 4'h1;
          end
        end
      end
      default:
        s_d.bus = BUS_IDLE;
    endcase
    if (bus_start)
    begin
      s_d.bus = BUS_ADDR;
      s_d.bits = 4'h0;
      s_d.oe_n = 1'b1;
    end
    else if (bus_stop)
    begin
      s_d.bus = BUS_IDLE;
      s_d.oe_n = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_NRST)
    begin
      s_q <= '0;
      s_q.trip_q <= CAPTURE_RST;
      s_q.swc_q <= CAPTURE_RST;
      s_q.scl_p <= 1'b1;
      s_q.sda_p <= 1'b1;
      s_q.oe_n <= 1'b1;
    end
    else
      s_q <= s_d;
    O_SDA_OUT <= 1'b0;
    O_SDA_OE_N <= !I_NRST || s_d.oe_n;
    O_ON_BATTERY <= I_NRST && (s_d.mon == MON_BATT);
    O_TUNE_BUSY <= I_NRST && (s_d.mon == MON_TUNE);
    O_FAST_SAMPLING <= I_NRST && (s_d.mon == MON_WATCH);
  end

endmodule : slm_monitor

// >>> verification/slm_i2c_host.sv
// I2C host model that reads the monitor's capture registers.
// Assumes a pull-up resolves SDA from sda_low and the target.
`timescale 1ns/1ps
module slm_i2c_host
(
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // ------------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------------
  // Each phase lasts H clocks so SCL stays far slower than the clock.
  localparam int H = 8;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task wt;
    repeat (H) @(posedge clk);
    #1;
  endtask : wt
  task start;
    sda_low = 1'b0;
    wt;
    scl = 1'b1;
    wt;
    sda_low = 1'b1;
    wt;
    scl = 1'b0;
    wt;
  endtask : start
  // Sends d then b9; the host reads SDA at every SCL high phase.
  task xfer(input logic [7:0] d, input logic b9, output logic [7:0] q,
    output logic r9);
    logic [8:0] v;
    v = {d, b9};
    for (int i = 8; i >= 0; i--)
    begin
      sda_low = !v[i];
      wt;
      scl = 1'b1;
      wt;
      if (i > 0)
        q[i-1] = sda;
      else
        r9 = sda;
      scl = 1'b0;
      wt;
    end
  endtask : xfer
  task stop;
    sda_low = 1'b1;
    wt;
    scl = 1'b1;
    wt;
    sda_low = 1'b0;
    wt;
  endtask : stop
endmodule : slm_i2c_host

// >>> verification/slm_chk.sv
// Checker for the supply loss monitor, watching its top ports.
// Assumes a bind to slm_monitor with the same parameters.
`timescale 1ns/1ps
module slm_chk
  import slm_pkg::*;
#(
  parameter int unsigned OBS_CYC = 40,
  parameter int unsigned TUNE_CYC = 2000
)
(
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic [15:0] I_RAIL_LEVEL,
  input wire logic [15:0] I_REF_LEVEL,
  input wire logic I_TUNE_START,
  input wire logic I_SCL,
  input wire logic I_SDA,
  input wire logic O_SDA_OUT,
  input wire logic O_SDA_OE_N,
  input wire logic O_ON_BATTERY,
  input wire logic O_TUNE_BUSY,
  input wire logic O_FAST_SAMPLING
);
  // ------------------------------------------------------------------
  // Helpers and properties
  // ------------------------------------------------------------------
  // Once tuned the threshold is internal, so threshold checks stop.
  logic tuned_q;
  logic [11:0] fast_q;
  logic [23:0] tune_q;
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_NRST)
    begin
      tuned_q <= 1'b0;
      fast_q <= '0;
      tune_q <= '0;
    end
    else
    begin
      tuned_q <= tuned_q | (tune_q != 0 && !O_TUNE_BUSY);
      fast_q <= O_FAST_SAMPLING ? fast_q + 12'h001 : 12'h000;
      tune_q <= O_TUNE_BUSY ? tune_q + 24'h000001 : 24'h000000;
    end
  end
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  sequence s_trip;
    $rose(O_FAST_SAMPLING);
  endsequence
  sequence s_switch;
    $rose(O_ON_BATTERY);
  endsequence
  a_trip_below_ref: assert property (
    s_trip and !tuned_q |-> $past(I_RAIL_LEVEL) < $past(I_REF_LEVEL))
    else $error("bad trip");
  a_switch_still_low: assert property (
    s_switch and !tuned_q |-> $past(I_RAIL_LEVEL) < $past(I_REF_LEVEL))
    else $error("bad switch");
  a_switch_ends_watch: assert property (
    s_switch |-> $fell(O_FAST_SAMPLING) && fast_q >= OBS_CYC - 1)
    else $error("switch before window");
  a_fast_period: assert property (
    $fell(O_FAST_SAMPLING) |-> fast_q <= FAST_CYC + 2)
    else $error("watch tick too slow");
  a_return_good: assert property (
    $fell(O_ON_BATTERY) && !tuned_q |->
    $past(I_RAIL_LEVEL) >= $past(I_REF_LEVEL))
    else $error("early return");
  a_no_tune_backup: assert property (
    O_TUNE_BUSY |-> !O_ON_BATTERY)
    else $error("backup during tune");
  a_tune_length: assert property (
    $fell(O_TUNE_BUSY) |-> tune_q >= TUNE_CYC - 2 && tune_q <= TUNE_CYC + 2)
    else $error("tune length");
  a_sda_scl_high: assert property (
    I_SCL && $past(I_SCL) |-> $stable(O_SDA_OE_N))
    else $error("SDA moved with SCL high");
  a_sda_open_drain: assert property (
    O_SDA_OUT == 1'b0)
    else $error("SDA driven high");
endmodule : slm_chk

// >>> verification/slm_monitor_test.sv
// Testbench for the supply loss monitor: rail scenarios and I2C reads.
// Assumes slm_i2c_host as the host and a pull-up on SDA.
`timescale 1ns/1ps
module slm_monitor_test;
  import slm_pkg::*;
  // ------------------------------------------------------------------
  // Stimulus and checks
  // ------------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] rail = 16'h0032;
  logic [15:0] ref_l = 16'h002E;
  logic tune = 1'b0;
  wire scl;
  wire sda_low;
  wire sda_w;
  logic sda_out, oe_n, batt, busy, fast, a;
  logic [7:0] q;
  logic [15:0] w;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  assign sda_w = !(sda_low || !oe_n);
  slm_monitor #(.OBS_CYC(40), .TUNE_CYC(2000)) dut (.I_CLK_SYS(clk),
    .I_NRST(nrst), .I_RAIL_LEVEL(rail), .I_REF_LEVEL(ref_l),
    .I_TUNE_START(tune), .I_SCL(scl), .I_SDA(sda_w), .O_SDA_OUT(sda_out),
    .O_SDA_OE_N(oe_n), .O_ON_BATTERY(batt), .O_TUNE_BUSY(busy),
    .O_FAST_SAMPLING(fast));
  // The host reads back and writes one probe byte; tuning values are never changed.
  slm_i2c_host host (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(sda_low));
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  function logic pick(input int s);
    return s == 0 ? fast : (s == 1 ? batt : busy);
  endfunction : pick
  task wait_o(input string nm, input int s, input logic v, input int lim);
    for (int i = 0; i < lim && pick(s) !== v; i++)
      step(1);
    chk(nm, {15'h0, pick(s)}, {15'h0, v});
  endtask : wait_o
  task put(input logic [7:0] d);
    host.xfer(d, 1'b1, q, a);
  endtask : put
  task rd16(input logic [7:0] p);
    logic [7:0] lo;
    host.start();
    put(8'hD2);
    chk("addr_ack", {15'h0, a}, 16'h0000);
    put(p);
    host.start();
    put(8'hD3);
    host.xfer(8'hFF, 1'b0, lo, a);
    put(8'hFF);
    host.stop();
    w = {q, lo};
  endtask : rd16
  task report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #400_000;
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    step(5);
    nrst = 1'b1;
    chk("reset_out", {11'h0, oe_n, sda_out, batt, busy, fast}, 16'h0010);
    rd16(REG_SWC_LO);
    chk("swc_reset", w, CAPTURE_RST);
    $display("test reset done");
    rail = 16'h002C;
    wait_o("trip", 0, 1'b1, 1610);
    rail = 16'h0032;
    wait_o("spike_end", 0, 1'b0, 900);
    chk("spike_batt", {15'h0, batt}, 16'h0000);
    $display("test spike done");
    rail = 16'h0028;
    wait_o("trip2", 0, 1'b1, 1610);
    rail = 16'h0026;
    wait_o("switch", 1, 1'b1, 900);
    step(3300);
    chk("stay_batt", {15'h0, batt}, 16'h0001);
    rail = 16'h0032;
    wait_o("return", 1, 1'b0, 3300);
    $display("test backup done");
    rd16(REG_TRIP_LO);
    chk("trip_cap", w, 16'h0028);
    rd16(REG_SWC_LO);
    chk("swc_cap", w, 16'h0026);
    host.start();
    put(8'hD2);
    put(REG_TRIP_LO);
    put(8'h55);
    host.stop();
    rd16(REG_TRIP_LO);
    chk("read_only", w, 16'h0028);
    rd16(8'h06);
    chk("unmapped", w, 16'h0000);
    host.start();
    put(8'hD4);
    host.stop();
    chk("other_addr", {15'h0, a}, 16'h0001);
    $display("test registers done");
    tune = 1'b1;
    step(1);
    tune = 1'b0;
    wait_o("tune_busy", 2, 1'b1, 4);
    rail = 16'h001E;
    step(1900);
    chk("tune_batt", {15'h0, batt}, 16'h0000);
    wait_o("tune_end", 2, 1'b0, 400);
    rail = 16'h001D;
    step(1700);
    chk("tuned_idle", {15'h0, fast}, 16'h0000);
    rail = 16'h001B;
    wait_o("tuned_trip", 0, 1'b1, 1610);
    $display("test tune done");
    report_and_stop();
  end
endmodule : slm_monitor_test
bind slm_monitor slm_chk #(.OBS_CYC(OBS_CYC), .TUNE_CYC(TUNE_CYC)) chk_i (
  .I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_RAIL_LEVEL(I_RAIL_LEVEL),
  .I_REF_LEVEL(I_REF_LEVEL), .I_TUNE_START(I_TUNE_START), .I_SCL(I_SCL),
  .I_SDA(I_SDA), .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE_N(O_SDA_OE_N),
  .O_ON_BATTERY(O_ON_BATTERY), .O_TUNE_BUSY(O_TUNE_BUSY),
  .O_FAST_SAMPLING(O_FAST_SAMPLING));
